/* design/pmb_register_bank.sv */
// Management register bank (control, status, identifier) for two PHY ports
`timescale 1ns/100ps
`default_nettype none

module pmb_register_bank #(
    parameter int PREAMBLE_BITS = pmb_pkg::PREAMBLE_BITS_DEF, // Ones needed before a start
    parameter logic [15:0] PHY_IDENTIFIER_UPPER = 16'h1234, // Arbitrary value
    parameter logic [15:0] PHY_IDENTIFIER_LOWER = 16'h5678 // Arbitrary value
) (
    input wire logic i_mclk, // System clock, 10 MHz
    input wire logic i_sys_rst, // Synchronous reset, active high
    input wire logic i_mdc, // Management clock pin
    input wire logic i_mdio_in, // Management data pin, input side
    output logic o_mdio_out, // Management data pin, output side
    output logic o_mdio_oe, // Management data drive enable, high drives
    input wire logic [4:0] i_phy1_mgmt_address, // Address of first PHY
    input wire logic [4:0] i_phy2_mgmt_address, // Address of second PHY
    input wire logic [pmb_pkg::NUM_PORTS-1:0] i_sw_ctl_we, // Switch-side control write
    input wire logic [15:0] i_sw_ctl_wdata, // Switch-side data, control layout
    input wire logic [pmb_pkg::NUM_PORTS-1:0] i_an_complete, // Auto-negotiation done
    input wire logic [pmb_pkg::NUM_PORTS-1:0] i_far_end_fault, // Far-end fault seen
    input wire logic [pmb_pkg::NUM_PORTS-1:0] i_link_up, // Link is up
    output logic [pmb_pkg::NUM_PORTS-1:0] o_far_end_loopback, // Loopback at this PHY
    output logic [pmb_pkg::NUM_PORTS-1:0] o_force_100, // Forced speed 100
    output logic [pmb_pkg::NUM_PORTS-1:0] o_an_enable, // Auto-negotiation on
    output logic [pmb_pkg::NUM_PORTS-1:0] o_power_down, // Port powered down
    output logic [pmb_pkg::NUM_PORTS-1:0] o_restart_an, // Restart pulse
    output logic [pmb_pkg::NUM_PORTS-1:0] o_force_full_duplex, // Forced full duplex
    output logic [pmb_pkg::NUM_PORTS-1:0] o_crossover_variant_select, // 1 first variant
    output logic [pmb_pkg::NUM_PORTS-1:0] o_force_mdi, // Straight-through forced
    output logic [pmb_pkg::NUM_PORTS-1:0] o_disable_mdix, // Crossover detect off
    output logic [pmb_pkg::NUM_PORTS-1:0] o_disable_far_end_fault, // Fault detect off
    output logic [pmb_pkg::NUM_PORTS-1:0] o_disable_transmit, // Transmitter off
    output logic [pmb_pkg::NUM_PORTS-1:0] o_disable_led // LED outputs off
);
    import pmb_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    // Preamble counter is six bits wide and saturates at the threshold
    generate
        if (PREAMBLE_BITS < 1 || PREAMBLE_BITS > 32) begin : g_bad_preamble
            $error("PREAMBLE_BITS must lie between 1 and 32");
        end
    endgenerate

    localparam logic [5:0] PRE_CNT = 6'(PREAMBLE_BITS);

    // ****************************************************************
    // Helper functions
    // ****************************************************************
    // Status word from live port state
    function automatic logic [15:0] build_status(input logic an_en, input logic an_done,
                                                 input logic fef, input logic link);
        logic [15:0] s;
        s = STS_ABILITY_BITS;
        s[STS_AN_COMPLETE] = an_done;
        s[STS_FAR_END_FAULT] = fef;
        s[STS_AN_ABLE] = an_en;
        s[STS_LINK_UP] = link;
        return s;
    endfunction : build_status

    // Read mux per register index; unmapped indices answer zero
    function automatic logic [15:0] read_word(input logic [4:0] idx, input logic [15:0] ctl,
                                              input logic [15:0] sts);
        logic [15:0] w;
        w = 16'h0000;
        case (idx)
            REG_BASIC_CONTROL: begin
                w = ctl & CTL_WR_MASK;
            end
            REG_BASIC_STATUS: begin
                w = sts;
            end
            REG_PHY_IDENTIFIER_UPPER: begin
                w = PHY_IDENTIFIER_UPPER;
            end
            REG_PHY_IDENTIFIER_LOWER: begin
                w = PHY_IDENTIFIER_LOWER;
            end
            default: begin
                w = 16'h0000;
            end
        endcase
        return w;
    endfunction : read_word

    // ****************************************************************
    // Pin synchronisers and clock edge detection
    // ****************************************************************
    logic mdc_s1_q;
    logic mdc_s2_q;
    logic mdc_s3_q;
    logic mdio_s1_q;
    logic mdio_s2_q;
    logic mdc_rise;

    // Two stages before any logic looks at the pins
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mdc_s1_q <= 1'b0;
            mdc_s2_q <= 1'b0;
            mdc_s3_q <= 1'b0;
            mdio_s1_q <= 1'b1;
            mdio_s2_q <= 1'b1;
        end else begin
            mdc_s1_q <= i_mdc;
            mdc_s2_q <= mdc_s1_q;
            mdc_s3_q <= mdc_s2_q;
            mdio_s1_q <= i_mdio_in;
            mdio_s2_q <= mdio_s1_q;
        end
    end

    // Data and clock share the same delay, so sampling stays aligned
    assign mdc_rise = mdc_s2_q & ~mdc_s3_q;

    // ****************************************************************
    // Per-port control registers
    // ****************************************************************
    logic [15:0] ctl_word [NUM_PORTS];
    logic [15:0] sts_word [NUM_PORTS];
    logic [NUM_PORTS-1:0] mii_we;
    logic [15:0] mii_wdata;

    generate
        for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
            pmb_port_regs u_regs (
                .i_mclk(i_mclk),
                .i_sys_rst(i_sys_rst),
                .i_mii_we(mii_we[p]),
                .i_mii_wdata(mii_wdata),
                .i_sw_we(i_sw_ctl_we[p]),
                .i_sw_wdata(i_sw_ctl_wdata),
                .o_ctl_q(ctl_word[p])
            );

            // Switch-facing controls come straight from the stored word
            assign o_far_end_loopback[p] = ctl_word[p][CTL_LOOPBACK];
            assign o_force_100[p] = ctl_word[p][CTL_FORCE_100];
            assign o_an_enable[p] = ctl_word[p][CTL_AN_ENABLE];
            assign o_power_down[p] = ctl_word[p][CTL_POWER_DOWN];
            assign o_restart_an[p] = ctl_word[p][CTL_RESTART_AN];
            assign o_force_full_duplex[p] = ctl_word[p][CTL_FORCE_FULL];
            assign o_crossover_variant_select[p] = ctl_word[p][CTL_XOVER_VARIANT];
            assign o_force_mdi[p] = ctl_word[p][CTL_FORCE_MDI];
            assign o_disable_mdix[p] = ctl_word[p][CTL_DISABLE_MDIX];
            assign o_disable_far_end_fault[p] = ctl_word[p][CTL_DISABLE_FEF];
            assign o_disable_transmit[p] = ctl_word[p][CTL_DISABLE_TX];
            assign o_disable_led[p] = ctl_word[p][CTL_DISABLE_LED];

            // Status view tracks the switch-side inputs live
            assign sts_word[p] = build_status(ctl_word[p][CTL_AN_ENABLE], i_an_complete[p],
                                              i_far_end_fault[p], i_link_up[p]);
        end
    endgenerate

    // ****************************************************************
    // Frame receiver
    // ****************************************************************
    pmb_state_t state_q;
    logic [5:0] cnt_q;
    logic [11:0] hdr_q;
    logic [11:0] hdr_full;
    logic [15:0] sh_q;
    logic port_sel_q;
    logic rd_q;
    logic wr_q;
    logic addr_hit1;
    logic addr_hit2;
    logic [15:0] rd_word;

    // Header word complete with the bit on the pin now
    assign hdr_full = {hdr_q[10:0], mdio_s2_q};
    // Address compare against the relocatable PHY addresses
    assign addr_hit1 = (hdr_full[9:5] == i_phy1_mgmt_address);
    assign addr_hit2 = (hdr_full[9:5] == i_phy2_mgmt_address);
    // Word loaded for a read, selected by port and register index
    assign rd_word = read_word(hdr_q[4:0], ctl_word[port_sel_q], sts_word[port_sel_q]);

    // Sequencer advances only on a detected management clock rise
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            state_q <= ST_PREAMBLE;
            cnt_q <= 6'h00;
            hdr_q <= 12'h000;
            port_sel_q <= 1'b0;
            rd_q <= 1'b0;
            wr_q <= 1'b0;
        end else if (mdc_rise) begin
            case (state_q)
                ST_PREAMBLE: begin
                    if (mdio_s2_q) begin
                        if (cnt_q < PRE_CNT) begin
                            cnt_q <= cnt_q + 6'h01;
                        end
                    end else if (cnt_q >= PRE_CNT) begin
                        state_q <= ST_START;
                    end else begin
                        cnt_q <= 6'h00;
                    end
                end
                ST_START: begin
                    cnt_q <= 6'h00;
                    // A bad start pattern drops back to hunting for ones
                    state_q <= mdio_s2_q ? ST_HEADER : ST_PREAMBLE;
                end
                ST_HEADER: begin
                    hdr_q <= hdr_full;
                    if (cnt_q == HDR_BITS - 6'h01) begin
                        cnt_q <= 6'h00;
                        state_q <= ST_TURNAROUND;
                        port_sel_q <= ~addr_hit1 & addr_hit2;
                        rd_q <= (addr_hit1 | addr_hit2) & (hdr_full[11:10] == OP_READ);
                        wr_q <= (addr_hit1 | addr_hit2) & (hdr_full[11:10] == OP_WRITE);
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                ST_TURNAROUND: begin
                    if (cnt_q == TA_BITS - 6'h01) begin
                        cnt_q <= 6'h00;
                        state_q <= ST_DATA;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                ST_DATA: begin
                    if (cnt_q == DATA_BITS - 6'h01) begin
                        cnt_q <= 6'h00;
                        state_q <= ST_PREAMBLE;
                        rd_q <= 1'b0;
                        wr_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 6'h01;
                    end
                end
                default: begin
                    cnt_q <= 6'h00;
                    state_q <= ST_PREAMBLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Data shifter and pin driver
    // ****************************************************************
    // One register serves both directions: reads shift out of the top,
    // writes shift in at the bottom; our own driven bits are harmless
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            sh_q <= 16'h0000;
            o_mdio_out <= 1'b1;
            o_mdio_oe <= 1'b0;
        end else if (mdc_rise) begin
            if (state_q == ST_TURNAROUND && cnt_q == 6'h00) begin
                // Station owns the first turnaround bit; drive zero in the second
                sh_q <= rd_word;
                o_mdio_oe <= rd_q;
                o_mdio_out <= 1'b0;
            end else if (state_q == ST_TURNAROUND || state_q == ST_DATA) begin
                sh_q <= {sh_q[14:0], mdio_s2_q};
                o_mdio_out <= sh_q[15];
                if (state_q == ST_DATA && cnt_q == DATA_BITS - 6'h01) begin
                    // Last bit already sampled by the station; let go
                    o_mdio_oe <= 1'b0;
                    o_mdio_out <= 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Write commit
    // ****************************************************************
    // Pulse once the sixteenth data bit is in; late change costs nothing
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            mii_we <= '0;
            mii_wdata <= 16'h0000;
        end else begin
            mii_we <= '0;
            // Only the control index holds writable bits; other indices are read-only
            if (mdc_rise && state_q == ST_DATA && cnt_q == DATA_BITS - 6'h01 && wr_q
                && hdr_q[4:0] == REG_BASIC_CONTROL) begin
                mii_we[port_sel_q] <= 1'b1;
                mii_wdata <= {sh_q[14:0], mdio_s2_q};
            end
        end
    end

endmodule : pmb_register_bank
`default_nettype wire

/* design/pmb_pkg.sv */
// Package of constants and types for the PHY management basic register bank
package pmb_pkg;

    // ****************************************************************
    // Register indices on the management interface
    // ****************************************************************
    localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
    localparam logic [4:0] REG_BASIC_STATUS = 5'h01;
    localparam logic [4:0] REG_PHY_IDENTIFIER_UPPER = 5'h02;
    localparam logic [4:0] REG_PHY_IDENTIFIER_LOWER = 5'h03;

    // Default management addresses, programmed by the host side
    localparam logic [4:0] PHY1_MGMT_ADDRESS_DEF = 5'h01;
    localparam logic [4:0] PHY2_MGMT_ADDRESS_DEF = 5'h02;

    // ****************************************************************
    // Basic control field positions
    // ****************************************************************
    localparam int CTL_LOOPBACK = 14;
    localparam int CTL_FORCE_100 = 13;
    localparam int CTL_AN_ENABLE = 12;
    localparam int CTL_POWER_DOWN = 11;
    localparam int CTL_RESTART_AN = 9;
    localparam int CTL_FORCE_FULL = 8;
    localparam int CTL_XOVER_VARIANT = 5;
    localparam int CTL_FORCE_MDI = 4;
    localparam int CTL_DISABLE_MDIX = 3;
    localparam int CTL_DISABLE_FEF = 2;
    localparam int CTL_DISABLE_TX = 1;
    localparam int CTL_DISABLE_LED = 0;

    // Writable bits; soft reset, isolate, collision test, reserved stay zero
    localparam logic [15:0] CTL_WR_MASK = 16'h7b3f;
    // Auto-negotiation enable and first crossover variant set after reset
    localparam logic [15:0] CTL_RESET_VAL = 16'h1020;

    // ****************************************************************
    // Basic status field positions
    // ****************************************************************
    localparam logic [15:0] STS_ABILITY_BITS = 16'h7800;
    localparam int STS_AN_COMPLETE = 5;
    localparam int STS_FAR_END_FAULT = 4;
    localparam int STS_AN_ABLE = 3;
    localparam int STS_LINK_UP = 2;

    // ****************************************************************
    // Management frame layout
    // ****************************************************************
    localparam logic [1:0] OP_READ = 2'b10;
    localparam logic [1:0] OP_WRITE = 2'b01;
    localparam logic [5:0] HDR_BITS = 6'h0c;
    localparam logic [5:0] TA_BITS = 6'h02;
    localparam logic [5:0] DATA_BITS = 6'h10;
    localparam int PREAMBLE_BITS_DEF = 32;
    localparam int NUM_PORTS = 2;

    // Frame receiver states
    typedef enum logic [2:0] {
        ST_PREAMBLE = 3'b000,
        ST_START = 3'b001,
        ST_HEADER = 3'b010,
        ST_TURNAROUND = 3'b011,
        ST_DATA = 3'b100
    } pmb_state_t;

endpackage : pmb_pkg

/* design/pmb_port_regs.sv */
// Per-port basic control register shared with the switch-side shadow bits
`timescale 1ns/100ps
`default_nettype none

module pmb_port_regs (
    input wire logic i_mclk, // System clock
    input wire logic i_sys_rst, // Synchronous reset, active high
    input wire logic i_mii_we, // Write pulse from management frame
    input wire logic [15:0] i_mii_wdata, // Management write data
    input wire logic i_sw_we, // Write pulse from switch-side register
    input wire logic [15:0] i_sw_wdata, // Switch-side data, control layout
    output logic [15:0] o_ctl_q // Current control word
);
    import pmb_pkg::*;

    logic [15:0] ctl_q;
    logic [15:0] ctl_d;

    // ****************************************************************
    // Next value
    // ****************************************************************
    // Management write beats a same-cycle switch write; restart self-clears
    always_comb begin
        ctl_d = ctl_q;
        ctl_d[CTL_RESTART_AN] = 1'b0;
        if (i_mii_we) begin
            ctl_d = i_mii_wdata & CTL_WR_MASK;
        end else if (i_sw_we) begin
            ctl_d = i_sw_wdata & CTL_WR_MASK;
        end
    end

    // Storage with documented reset values
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            ctl_q <= CTL_RESET_VAL;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    assign o_ctl_q = ctl_q;

endmodule : pmb_port_regs
`default_nettype wire

/* verification/pmb_register_bank_monitor.sv */
// Checker of control outputs against reset values and switch-side writes
`timescale 1ns/100ps
`default_nettype none

module pmb_register_bank_monitor (
    input wire logic i_mclk, // Clock
    input wire logic i_sys_rst, // Reset
    input wire logic [1:0] i_sw_ctl_we, // Switch write
    input wire logic [15:0] i_sw_ctl_wdata, // Switch data
    input wire logic [1:0] o_far_end_loopback, // Loopback
    input wire logic [1:0] o_an_enable, // Autoneg on
    input wire logic [1:0] o_power_down, // Power down
    input wire logic [1:0] o_restart_an, // Restart
    input wire logic [1:0] o_crossover_variant_select, // Variant
    input wire logic [1:0] o_force_mdi, // Straight
    input wire logic [1:0] o_disable_transmit, // Tx off
    input wire logic [1:0] o_disable_led // LED off
);
    logic [15:0] wd_q;

    // Switch data of the previous cycle, to compare after the write lands
    always_ff @(posedge i_mclk) begin
        wd_q <= i_sw_ctl_wdata;
    end

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_rst;
        $fell(i_sys_rst) |-> o_an_enable == 2'b11 && o_crossover_variant_select == 2'b11
            && (o_far_end_loopback | o_disable_led | o_power_down) == 2'b00;
    endproperty
    a_rst: assert property (p_rst) else $error("Control outputs wrong after reset");
    property p_loop;
        i_sw_ctl_we[0] |=> o_far_end_loopback[0] == wd_q[14];
    endproperty
    a_loop: assert property (p_loop) else $error("Loopback of port one not shadowed");
    property p_loop2;
        i_sw_ctl_we[1] |=> o_far_end_loopback[1] == wd_q[14];
    endproperty
    a_loop2: assert property (p_loop2) else $error("Loopback of port two not shadowed");
    property p_pdn;
        i_sw_ctl_we[1] |=> {o_an_enable[1], o_power_down[1]} == wd_q[12:11];
    endproperty
    a_pdn: assert property (p_pdn) else $error("Autoneg or power down not shadowed");
    property p_xover;
        i_sw_ctl_we[0] |=> {o_crossover_variant_select[0], o_force_mdi[0]} == wd_q[5:4];
    endproperty
    a_xover: assert property (p_xover) else $error("Crossover bits not shadowed");
    property p_txled;
        i_sw_ctl_we[1] |=> {o_disable_transmit[1], o_disable_led[1]} == wd_q[1:0];
    endproperty
    a_txled: assert property (p_txled) else $error("Transmit or LED disable not shadowed");
    property p_rs;
        i_sw_ctl_we[0] && i_sw_ctl_wdata[9] |=> o_restart_an[0] ##1 !o_restart_an[0];
    endproperty
    a_rs: assert property (p_rs) else $error("Restart is not a single pulse");
    property p_rs_pulse;
        o_restart_an[1] |=> !o_restart_an[1];
    endproperty
    a_rs_pulse: assert property (p_rs_pulse) else $error("Restart held longer than one cycle");
endmodule : pmb_register_bank_monitor

bind pmb_register_bank pmb_register_bank_monitor pmb_register_bank_monitor_inst (.*);
`default_nettype wire

/* verification/pmb_station_model.sv */
// Management station model: makes the management clock and frames
`timescale 1ns/100ps
`default_nettype none

module pmb_station_model (
    input wire logic i_mdio, // Resolved data wire
    output logic o_mdc, // Clock, low between frames
    output logic o_mdio, // Data from the station
    output logic o_mdio_oe // High while station drives
);
    // Idle: clock still, pin released
    initial begin
        o_mdc = 1'b0;
        o_mdio = 1'b1;
        o_mdio_oe = 1'b0;
    end

    // One frame, bits set up while the clock is low; read data taken at the rise
    task automatic frame(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                         input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hffffffff, 2'b01, op, pa, ra, 2'b10, wd};
        rd = 16'h0000;
        #13 o_mdio_oe = 1'b1;
        for (int i = 63; i >= 0; i--) begin
            if (op == pmb_pkg::OP_READ && i == 17) o_mdio_oe = 1'b0;
            o_mdio = f[i];
            #400 o_mdc = 1'b1;
            if (i < 16) rd[i] = i_mdio;
            #400 o_mdc = 1'b0;
        end
        o_mdio_oe = 1'b0;
    endtask : frame
endmodule : pmb_station_model
`default_nettype wire

/* verification/tb_top.sv */
// Self-checking bench for the PHY management basic register bank
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import pmb_pkg::*;
    localparam logic [15:0] ID_HI = 16'h4a5b; // Arbitrary value
    localparam logic [15:0] ID_LO = 16'h6c7d; // Arbitrary value
    logic i_mclk = 1'b0;
    logic i_sys_rst = 1'b1;
    logic mdc, st_out, st_oe, dut_out, dut_oe, mdio_w;
    logic [4:0] addr1 = 5'h01;
    logic [1:0] sw_we = 2'b00;
    logic [15:0] sw_wd = 16'h0000;
    logic [1:0] an = 2'b00;
    logic [1:0] fef = 2'b00;
    logic [1:0] link = 2'b00;
    logic [1:0] loop, f100, ane, pd, rs, ffd, xv, mdi, dmx, dfef, dtx, dled;
    int miscompares = 0;
    int tests_run = 0;
    int rs_cnt = 0;
    int cyc = 0;

    // Pull-up holds the wire high when nobody drives
    assign mdio_w = dut_oe ? dut_out : (st_oe ? st_out : 1'b1);
    // 10 MHz clock
    always #50 i_mclk = ~i_mclk;
    // Count restart pulses; a stuck level would count many times
    always @(posedge i_mclk) rs_cnt <= rs_cnt + rs[0] + rs[1];
    // Cut a hang short
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            miscompares++;
            print_verdict();
        end
    end

    pmb_register_bank #(.PREAMBLE_BITS(2), .PHY_IDENTIFIER_UPPER(ID_HI), .PHY_IDENTIFIER_LOWER(ID_LO))
    pmb_register_bank_inst (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_mdc(mdc), .i_mdio_in(mdio_w),
        .o_mdio_out(dut_out), .o_mdio_oe(dut_oe), .i_phy1_mgmt_address(addr1), .i_phy2_mgmt_address(5'h02),
        .i_sw_ctl_we(sw_we), .i_sw_ctl_wdata(sw_wd), .i_an_complete(an), .i_far_end_fault(fef),
        .i_link_up(link), .o_far_end_loopback(loop), .o_force_100(f100), .o_an_enable(ane),
        .o_power_down(pd), .o_restart_an(rs), .o_force_full_duplex(ffd), .o_crossover_variant_select(xv),
        .o_force_mdi(mdi), .o_disable_mdix(dmx), .o_disable_far_end_fault(dfef), .o_disable_transmit(dtx),
        .o_disable_led(dled));
    pmb_station_model pmb_station_model_inst (.i_mdio(mdio_w), .o_mdc(mdc), .o_mdio(st_out), .o_mdio_oe(st_oe));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] ov(input int p);
        return {1'b0, loop[p], f100[p], ane[p], pd[p], 1'b0, rs[p], ffd[p], 2'b00, xv[p], mdi[p], dmx[p],
                dfef[p], dtx[p], dled[p]};
    endfunction : ov
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask : chk
    task automatic rc(input string n, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] e);
        logic [15:0] d;
        pmb_station_model_inst.frame(OP_READ, pa, ra, 16'h0000, d);
        chk(n, e, d);
    endtask : rc
    // Commit lands a few cycles after the last clock rise
    task automatic wr(input logic [4:0] pa, input logic [15:0] v);
        logic [15:0] d;
        pmb_station_model_inst.frame(OP_WRITE, pa, REG_BASIC_CONTROL, v, d);
        repeat (4) @(negedge i_mclk);
    endtask : wr

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_defaults();
        for (int p = 1; p <= 2; p++) begin
            rc("control", 5'(p), REG_BASIC_CONTROL, 16'h1020);
            rc("status", 5'(p), REG_BASIC_STATUS, 16'h7808);
            rc("id_upper", 5'(p), REG_PHY_IDENTIFIER_UPPER, ID_HI);
            rc("id_lower", 5'(p), REG_PHY_IDENTIFIER_LOWER, ID_LO);
            chk("outputs", 16'h1020, ov(p - 1));
        end
        rc("unmapped", 5'h01, 5'h06, 16'h0000);
    endtask : t_defaults
    task automatic t_status();
        @(negedge i_mclk);
        an = 2'b01;
        fef = 2'b10;
        link = 2'b01;
        rc("status1", 5'h01, REG_BASIC_STATUS, 16'h782c);
        rc("status2", 5'h02, REG_BASIC_STATUS, 16'h7818);
    endtask : t_status
    task automatic t_write();
        int base;
        logic [15:0] d;
        base = rs_cnt;
        wr(5'h02, 16'hffff);
        chk("port2_out", 16'h793f, ov(1));
        chk("port1_out", 16'h1020, ov(0));
        chk("restart", 16'h0001, 16'(rs_cnt - base));
        rc("control2", 5'h02, REG_BASIC_CONTROL, 16'h793f);
        wr(5'h02, 16'h0000);
        chk("port2_zero", 16'h0000, ov(1));
        rc("status2_an", 5'h02, REG_BASIC_STATUS, 16'h7810);
        wr(5'h01, 16'h2100);
        chk("port1_force", 16'h2100, ov(0));
        // A write aimed at a read-only index must leave control alone
        pmb_station_model_inst.frame(OP_WRITE, 5'h01, REG_BASIC_STATUS, 16'h0000, d);
        repeat (4) @(negedge i_mclk);
        chk("port1_ro_write", 16'h2100, ov(0));
    endtask : t_write
    task automatic t_switch();
        logic [15:0] wd [2] = '{16'hc21c, 16'h8842};
        logic [15:0] ex [2] = '{16'h401c, 16'h0802};
        int base;
        for (int p = 0; p < 2; p++) begin
            base = rs_cnt;
            @(negedge i_mclk);
            sw_we[p] = 1'b1;
            sw_wd = wd[p];
            @(negedge i_mclk);
            sw_we = 2'b00;
            repeat (2) @(negedge i_mclk);
            chk("shadow_out", ex[p], ov(p));
            chk("shadow_restart", {15'h0, wd[p][9]}, 16'(rs_cnt - base));
            rc("shadow_read", 5'(p + 1), REG_BASIC_CONTROL, ex[p]);
        end
    endtask : t_switch
    task automatic t_reloc();
        @(negedge i_mclk);
        addr1 = 5'h05;
        rc("moved", 5'h05, REG_PHY_IDENTIFIER_UPPER, ID_HI);
        rc("old", 5'h01, REG_PHY_IDENTIFIER_UPPER, 16'hffff);
    endtask : t_reloc
    task automatic t_reset();
        @(negedge i_mclk);
        i_sys_rst = 1'b1;
        repeat (12) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        @(negedge i_mclk);
        chk("reset0", 16'h1020, ov(0));
        chk("reset1", 16'h1020, ov(1));
    endtask : t_reset
    task automatic print_verdict();
        $display("tests_run %0d miscompares %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    // Main sequence
    initial begin
        repeat (12) @(negedge i_mclk);
        i_sys_rst = 1'b0;
        t_defaults();
        t_status();
        t_write();
        t_switch();
        t_reloc();
        t_reset();
        print_verdict();
    end
endmodule : tb_top
`default_nettype wire
